// [hdl/ssst_pkg.sv]
// shared constants, register map and state layout of the spi slave shifter timer
package ssst_pkg;

    localparam int unsigned SHIFT_WIDTH   = 32;
    localparam int unsigned COUNT_WIDTH   = 16;
    localparam int unsigned BITS_WIDTH    = 6;
    localparam int unsigned STATUS_WIDTH  = 5;
    localparam int unsigned ADDR_WIDTH    = 8;

    // register byte offsets on the apb slave
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_TXDATA  = 8'h04;
    localparam logic [7:0] ADDR_RXDATA  = 8'h08;
    localparam logic [7:0] ADDR_STATUS  = 8'h0c;
    localparam logic [7:0] ADDR_MASK    = 8'h10;
    localparam logic [7:0] ADDR_BUFSTAT = 8'h14;

    // control register fields
    localparam int unsigned CTRL_ENABLE_POS = 0;
    localparam int unsigned CTRL_BITS_LSB   = 8;

    // sticky status bit positions, shared by the mask register
    localparam int unsigned ST_TX_EMPTY  = 0;
    localparam int unsigned ST_RX_FULL   = 1;
    localparam int unsigned ST_TX_UNDER  = 2;
    localparam int unsigned ST_RX_OVER   = 3;
    localparam int unsigned ST_FRAME_END = 4;

    // values after reset
    localparam logic [5:0]  CTRL_BITS_RESET = 6'h08;
    localparam logic [15:0] COMPARE_RESET   = 16'h000f;
    localparam logic [2:0]  CS_SYNC_RESET   = 3'h7;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } ssst_apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } ssst_apb_rsp_type;

    typedef struct packed {
        logic [2:0]       sclkSync;
        logic [2:0]       csSync;
        logic [1:0]       dinSync;
        logic             enable;
        logic [5:0]       bitCount;
        logic [15:0]      compare;
        logic             timerOn;
        logic             timerOut;
        logic [15:0]      count;
        logic [31:0]      txShift;
        logic [31:0]      txBuf;
        logic             txFull;
        logic [31:0]      rxShift;
        logic [31:0]      rxBuf;
        logic             rxValid;
        logic [4:0]       status;
        logic [4:0]       mask;
        logic             irq;
        logic             dataOut;
        logic             dataOe;
        ssst_apb_rsp_type apbRsp;
    } ssst_state_type;

    localparam ssst_state_type SSST_STATE_RESET = '{
        csSync:   CS_SYNC_RESET,
        bitCount: CTRL_BITS_RESET,
        compare:  COMPARE_RESET,
        default:  '0
    };

endpackage : ssst_pkg

// [hdl/ssst_spi_slave.sv]
// spi slave: transmit and receive shifters paced by a select-triggered edge timer
//
// Function
// - transmit shifter drives pin four, output enabled, active high, timed by the timer
// - transmit shifter moves to its next bit on each falling shift clock edge
// - receive shifter takes pin five as input only, active high, same timer
// - receive shifter samples its data bit on each rising shift clock edge
// - no start or stop bits; transmit buffer loads into shifter when timer enables
// - both shifter buffers are seen with bit order swapped within each byte, byte order kept
// - clock and select pins are inputs; the external master drives both
// - timer trigger is the select on pin seven, taken active low
// - the timer is one 16-bit counter, not two 8-bit halves
// - timer decrements on pin six edges, which also clock the shifters
// - timer enables on the rising edge of its polarity-corrected trigger
// - once on, no compare disables the timer and nothing resets its counter
// - timer output starts at zero on enable, unaffected by any timer reset
// - compare value equals twice the transfer size minus one
// - while select is asserted, data moves at every serial clock edge
// - the slave uses the master's clock and makes no bit-rate clock
//
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps

module ssst_spi_slave (
    input  wire logic                      clock,        // 20 MHz block clock
    input  wire logic                      rst_n,        // async reset, active low
    input  wire ssst_pkg::ssst_apb_req_type apbReq,      // apb request from master
    output      ssst_pkg::ssst_apb_rsp_type apbRsp,      // apb answer
    output      logic                      irq,          // level interrupt
    output      logic                      ioPinFour,    // serial data out
    output      logic                      ioPinFourOe,  // output enable of pin four
    input  wire logic                      ioPinFive,    // serial data in
    input  wire logic                      ioPinSix,     // serial clock from master
    input  wire logic                      ioPinSeven    // select from master, low active
);

    ssst_pkg::ssst_state_type st;
    ssst_pkg::ssst_state_type next_st;

    logic       sclkRise;
    logic       sclkFall;
    logic       sclkEdge;
    logic       trig;
    logic       trigRise;
    logic       trigFall;
    logic       active;
    logic       apbAccess;
    logic       apbDone;
    logic       rxStore;
    logic [4:0] evt;
    logic [31:0] readWord;
    logic        readErr;
    logic        txWrite;

    // reverse bits within every byte: bit order swapped, byte order kept
    function automatic logic [31:0] bbsSwap(input logic [31:0] w);
        logic [31:0] r;
        r = '0;
        for (int i = 0; i < 32; i++) begin
            r[(i / 8) * 8 + 7 - (i % 8)] = w[i];
        end
        return r;
    endfunction : bbsSwap

    // two edges per bit, so a word of n bits spans 2n counter steps
    function automatic logic [15:0] compareOf(input logic [5:0] bits);
        return {9'h000, bits, 1'b0} - 16'h0001;
    endfunction : compareOf

    // sync stage [1] is the clean level, [2] the previous one; [0] feeds only [1]
    assign sclkRise  = st.sclkSync[1] & ~st.sclkSync[2];
    assign sclkFall  = ~st.sclkSync[1] & st.sclkSync[2];
    assign sclkEdge  = sclkRise | sclkFall;
    assign trig      = ~st.csSync[1];
    assign trigRise  = trig & st.csSync[2];
    assign trigFall  = ~trig & ~st.csSync[2];
    assign active    = st.timerOn & trig;
    assign apbAccess = apbReq.psel & apbReq.penable;
    assign apbDone   = apbAccess & st.apbRsp.pready;
    assign txWrite   = apbDone & apbReq.pwrite & (apbReq.paddr == ssst_pkg::ADDR_TXDATA);

    always_comb begin
        readWord = 32'h0000_0000;
        readErr  = 1'b0;
        case (apbReq.paddr)
            ssst_pkg::ADDR_CTRL: begin
                readWord = {16'h0000, 2'b00, st.bitCount, 7'h00, st.enable};
            end
            ssst_pkg::ADDR_TXDATA: begin
                readWord = 32'h0000_0000;
            end
            ssst_pkg::ADDR_RXDATA: begin
                readWord = bbsSwap(st.rxBuf);
            end
            ssst_pkg::ADDR_STATUS: begin
                readWord = {27'h0000000, st.status};
            end
            ssst_pkg::ADDR_MASK: begin
                readWord = {27'h0000000, st.mask};
            end
            ssst_pkg::ADDR_BUFSTAT: begin
                readWord = {st.count, 12'h000, st.timerOut, st.timerOn, st.rxValid, st.txFull};
            end
            default: begin
                readErr = 1'b1;
            end
        endcase
    end

    always_comb begin
        next_st = st;
        evt     = 5'h00;
        rxStore = 1'b0;

        // pins are input only and pass two flops before any logic reads them
        next_st.sclkSync = {st.sclkSync[1:0], ioPinSix};
        next_st.csSync   = {st.csSync[1:0], ioPinSeven};
        next_st.dinSync  = {st.dinSync[0], ioPinFive};

        if (!st.enable) begin
            next_st.timerOn = 1'b0;
        end else if (!st.timerOn && trigRise) begin
            next_st.timerOn  = 1'b1;
            next_st.timerOut = 1'b0;
            next_st.count    = st.compare;
            next_st.txShift  = st.txBuf;
            next_st.txFull   = 1'b0;
            if (st.txFull) begin
                evt[ssst_pkg::ST_TX_EMPTY] = 1'b1;
            end else begin
                evt[ssst_pkg::ST_TX_UNDER] = 1'b1;
            end
        end else if (active && sclkEdge) begin
            // the shift clock is the pin itself; no divider exists here
            if (st.count == 16'h0000) begin
                next_st.count    = st.compare;
                next_st.timerOut = ~st.timerOut;
            end else begin
                next_st.count = st.count - 16'h0001;
            end
            if (sclkRise) begin
                next_st.rxShift = {st.dinSync[1], st.rxShift[31:1]};
            end
            if (sclkFall) begin
                if (st.count == 16'h0000) begin
                    // word boundary: a stale buffer is resent and flagged
                    next_st.txShift = st.txBuf;
                    next_st.txFull  = 1'b0;
                    if (st.txFull) begin
                        evt[ssst_pkg::ST_TX_EMPTY] = 1'b1;
                    end else begin
                        evt[ssst_pkg::ST_TX_UNDER] = 1'b1;
                    end
                end else begin
                    next_st.txShift = {1'b0, st.txShift[31:1]};
                end
            end
            if (st.count == 16'h0000) begin
                rxStore         = 1'b1;
                next_st.rxBuf   = next_st.rxShift;
                next_st.rxValid = 1'b1;
                evt[ssst_pkg::ST_RX_FULL] = 1'b1;
                if (st.rxValid) begin
                    evt[ssst_pkg::ST_RX_OVER] = 1'b1;
                end
            end
        end

        if (st.timerOn && trigFall) begin
            evt[ssst_pkg::ST_FRAME_END] = 1'b1;
        end
        next_st.status = st.status | evt;

        // apb: one wait state so that the answer comes from flops
        if (apbAccess && !st.apbRsp.pready) begin
            next_st.apbRsp.pready  = 1'b1;
            next_st.apbRsp.prdata  = readWord;
            next_st.apbRsp.pslverr = readErr;
        end else begin
            next_st.apbRsp.pready  = 1'b0;
            next_st.apbRsp.pslverr = 1'b0;
        end

        if (apbDone && apbReq.pwrite) begin
            case (apbReq.paddr)
                ssst_pkg::ADDR_CTRL: begin
                    next_st.enable   = apbReq.pwdata[ssst_pkg::CTRL_ENABLE_POS];
                    next_st.bitCount = apbReq.pwdata[ssst_pkg::CTRL_BITS_LSB +: 6];
                    next_st.compare  = compareOf(apbReq.pwdata[ssst_pkg::CTRL_BITS_LSB +: 6]);
                end
                ssst_pkg::ADDR_TXDATA: begin
                    // a write in the load cycle lands in the buffer for the next word
                    next_st.txBuf  = bbsSwap(apbReq.pwdata);
                    next_st.txFull = 1'b1;
                end
                ssst_pkg::ADDR_MASK: begin
                    next_st.mask = apbReq.pwdata[4:0];
                end
                default: begin
                end
            endcase
        end else if (apbDone) begin
            case (apbReq.paddr)
                ssst_pkg::ADDR_STATUS: begin
                    next_st.status = evt;                              // set wins over clear
                end
                ssst_pkg::ADDR_RXDATA: begin
                    if (!rxStore) begin
                        next_st.rxValid = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        next_st.irq     = |(next_st.status & next_st.mask);
        next_st.dataOut = next_st.txShift[0];
        // keep driving until the running timer has stopped as well
        next_st.dataOe  = next_st.enable | next_st.timerOn;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st <= ssst_pkg::SSST_STATE_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign apbRsp      = st.apbRsp;
    assign irq         = st.irq;
    assign ioPinFour   = st.dataOut;
    assign ioPinFourOe = st.dataOe;

    // checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    property p_pinFourDriven;
        st.timerOn |-> (ioPinFourOe && ioPinFour == st.txShift[0]);
    endproperty
    a_pinFourDriven: assert property (p_pinFourDriven) else $error("pin four not driven");

    property p_txShiftOnFall;
        (active && sclkFall && st.count != 16'h0000) |=> (st.txShift == ($past(st.txShift) >> 1));
    endproperty
    a_txShiftOnFall: assert property (p_txShiftOnFall) else $error("tx did not shift");

    property p_rxSamplePin;
        (active && sclkRise) |=> (st.rxShift[31] == $past(st.dinSync[1]));
    endproperty
    a_rxSamplePin: assert property (p_rxSamplePin) else $error("rx bit not from pin");

    property p_rxHoldOnFall;
        (active && sclkFall) |=> (st.rxShift == $past(st.rxShift));
    endproperty
    a_rxHoldOnFall: assert property (p_rxHoldOnFall) else $error("rx moved on fall");

    // a buffer write in the load cycle is kept for the next word
    property p_loadOnEnable;
        $rose(st.timerOn) |-> (st.txShift == $past(st.txBuf)
            && (!st.txFull || $past(txWrite)));
    endproperty
    a_loadOnEnable: assert property (p_loadOnEnable) else $error("no load on enable");

    property p_rxReadSwapped;
        (apbAccess && !st.apbRsp.pready && !apbReq.pwrite && apbReq.paddr == ssst_pkg::ADDR_RXDATA)
            |=> (st.apbRsp.prdata == bbsSwap($past(st.rxBuf)));
    endproperty
    a_rxReadSwapped: assert property (p_rxReadSwapped) else $error("rx read not swapped");

    property p_trigActiveLow;
        $rose(st.timerOn) |-> !$past(st.csSync[1]);
    endproperty
    a_trigActiveLow: assert property (p_trigActiveLow) else $error("enable with select high");

    property p_wrapToCompare;
        (active && sclkEdge && st.count == 16'h0000) |=> (st.count == $past(st.compare));
    endproperty
    a_wrapToCompare: assert property (p_wrapToCompare) else $error("counter wrap wrong");

    property p_decrement;
        (active && sclkEdge && st.count != 16'h0000) |=> (st.count == $past(st.count) - 16'h0001);
    endproperty
    a_decrement: assert property (p_decrement) else $error("counter did not step");

    property p_enableOnRise;
        $rose(st.timerOn) |-> ($past(trigRise) && $past(st.enable));
    endproperty
    a_enableOnRise: assert property (p_enableOnRise) else $error("enable without trigger rise");

    property p_neverDisabled;
        (st.timerOn && st.enable) |=> st.timerOn;
    endproperty
    a_neverDisabled: assert property (p_neverDisabled) else $error("timer dropped");

    property p_startLow;
        $rose(st.timerOn) |-> (!st.timerOut && st.count == $past(st.compare));
    endproperty
    a_startLow: assert property (p_startLow) else $error("timer start level wrong");

    property p_compareValue;
        $changed(st.bitCount) |-> (st.compare == {9'h000, st.bitCount, 1'b0} - 16'h0001);
    endproperty
    a_compareValue: assert property (p_compareValue) else $error("compare not 2n-1");

    property p_idleNoShift;
        (!trig && !trigRise) |=> (st.txShift == $past(st.txShift));
    endproperty
    a_idleNoShift: assert property (p_idleNoShift) else $error("shift while deselected");

    property p_onlyPinEdges;
        (st.timerOn && !sclkEdge) |=> (st.rxShift == $past(st.rxShift) && st.count == $past(st.count));
    endproperty
    a_onlyPinEdges: assert property (p_onlyPinEdges) else $error("step without pin edge");

    property p_overflowFlag;
        (active && sclkEdge && st.count == 16'h0000 && st.rxValid)
            |=> st.status[ssst_pkg::ST_RX_OVER] ##1 st.irq == |(st.status & st.mask);
    endproperty
    a_overflowFlag: assert property (p_overflowFlag) else $error("overflow not flagged");

    property p_underflowFlag;
        (!st.timerOn && st.enable && trigRise && !st.txFull) |=> st.status[ssst_pkg::ST_TX_UNDER];
    endproperty
    a_underflowFlag: assert property (p_underflowFlag) else $error("underflow not flagged");

    property p_txBufWrite;
        txWrite |=> (st.txFull && st.txBuf == bbsSwap($past(apbReq.pwdata)));
    endproperty
    a_txBufWrite: assert property (p_txBufWrite) else $error("tx buffer write lost");

    property p_wordReload;
        (active && sclkFall && st.count == 16'h0000) |=> (st.txShift == $past(st.txBuf));
    endproperty
    a_wordReload: assert property (p_wordReload) else $error("no reload at word end");

    property p_rxFullFlag;
        (active && sclkEdge && st.count == 16'h0000)
            |=> (st.rxValid && st.status[ssst_pkg::ST_RX_FULL]);
    endproperty
    a_rxFullFlag: assert property (p_rxFullFlag) else $error("word store not flagged");

    property p_emptyFlag;
        (active && sclkFall && st.count == 16'h0000 && st.txFull)
            |=> st.status[ssst_pkg::ST_TX_EMPTY];
    endproperty
    a_emptyFlag: assert property (p_emptyFlag) else $error("buffer move not flagged");

    property p_frameEndFlag;
        (st.timerOn && trigFall) |=> st.status[ssst_pkg::ST_FRAME_END];
    endproperty
    a_frameEndFlag: assert property (p_frameEndFlag) else $error("frame end not flagged");

    property p_outputToggle;
        (active && sclkEdge && st.count == 16'h0000) |=> (st.timerOut != $past(st.timerOut));
    endproperty
    a_outputToggle: assert property (p_outputToggle) else $error("timer output stuck");

    property p_pinFourEnabled;
        st.enable |-> ioPinFourOe;
    endproperty
    a_pinFourEnabled: assert property (p_pinFourEnabled) else $error("pin four not enabled");

    property p_idleTimer;
        (!st.timerOn && !trigRise)
            |=> (st.count == $past(st.count) && st.txShift == $past(st.txShift));
    endproperty
    a_idleTimer: assert property (p_idleTimer) else $error("timer stepped while off");

    property p_readyAfterWait;
        (apbAccess && !st.apbRsp.pready) |=> st.apbRsp.pready;
    endproperty
    a_readyAfterWait: assert property (p_readyAfterWait) else $error("no apb answer");

    c_timerEnable: cover property ($rose(st.timerOn));
    c_wordStore: cover property (active && sclkFall && st.count == 16'h0000 ##1 st.rxValid);
    c_irqRaised: cover property ($rose(st.irq));
    c_frameEnd: cover property (st.timerOn && trigFall);
    c_underflowLoad: cover property (!st.timerOn && st.enable && trigRise && !st.txFull);

endmodule : ssst_spi_slave

// [tb/ssst_spi_master.sv]
// spi bus master model: mode zero, msb first, drives serial clock and select
`timescale 1ns/1ps

module ssst_spi_master (
    output logic      sck,  // serial clock, low between frames
    output logic      csN,  // select, active low
    output logic      mosi, // data towards the slave
    input  wire logic miso  // data from the slave
);
    logic [7:0] rxByte;
    event       doneEv;

    initial begin
        sck = 1'h0;
        csN = 1'h1;
        mosi = 1'h0;
    end

    // one frame at a time; the caller only returns once the frame is over
    task automatic frame(input logic [7:0] tx);
        // step off the block clock's rising edge so that no pin moves at a sample
        #10;
        csN = 1'h0;
        mosi = tx[7];
        #1000;
        for (int i = 7; i >= 0; i--) begin
            sck = 1'h1;
            // the slave's answer lags the fall by nearly three block clock cycles: sample late
            #180;
            rxByte[i] = miso;
            #20;
            sck = 1'h0;
            if (i > 0) mosi = tx[i-1];
            #200;
        end
        #400;
        csN = 1'h1;
        // a released line must not keep showing its last bit
        mosi = ~mosi;
        -> doneEv;
        #1000;
    endtask : frame
endmodule : ssst_spi_master

// [tb/test_ssst_spi_slave.sv]
// self-checking bench: apb register traffic and spi frames against the slave
`timescale 1ns/1ps

module test_ssst_spi_slave;
    typedef struct packed {
        logic [31:0] data;
        logic [31:0] msk;
        logic        err;
        logic        irq;
        logic        oe;
    } ssst_note_type;

    logic                       clock;
    logic                       rst_n;
    ssst_pkg::ssst_apb_req_type apbReq;
    ssst_pkg::ssst_apb_rsp_type apbRsp;
    logic                       irq;
    logic                       ioPinFour;
    logic                       ioPinFourOe;
    logic                       mosi;
    logic                       sck;
    logic                       csN;
    logic                       oeExp;
    logic [7:0]                 lastRx;
    logic [7:0]                 tx0;
    logic [7:0]                 tx1;
    int                         failures;
    int                         comparisons;
    int                         seed;
    ssst_note_type              apbQ[$];
    logic [7:0]                 spiQ[$];
    ssst_note_type              cur;

    ssst_spi_slave i_ssst_spi_slave (
        .clock      (clock),
        .rst_n      (rst_n),
        .apbReq     (apbReq),
        .apbRsp     (apbRsp),
        .irq        (irq),
        .ioPinFour  (ioPinFour),
        .ioPinFourOe(ioPinFourOe),
        .ioPinFive  (mosi),
        .ioPinSix   (sck),
        .ioPinSeven (csN)
    );

    ssst_spi_master i_ssst_spi_master (
        .sck (sck),
        .csN (csN),
        .mosi(mosi),
        .miso(ioPinFour)
    );

    initial begin
        clock = 1'h0;
        forever #25 clock = ~clock;
    end

    task automatic cmpWord(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : cmpWord

    task automatic cmpBit(input string name, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %b seen %b", name, exp, got);
        end
    endtask : cmpBit

    task automatic apbXfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        apbReq <= '{psel: 1'h1, penable: 1'h0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clock);
        apbReq.penable <= 1'h1;
        do @(posedge clock); while (apbRsp.pready !== 1'h1);
        apbReq <= '0;
    endtask : apbXfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apbXfer(1'h1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                      input logic e, input logic i);
        apbQ.push_back('{data: d, msk: m, err: e, irq: i, oe: oeExp});
        apbXfer(1'h0, a, 32'h0);
    endtask : rd

    // the slave must hand back expTx while the master sends a random byte
    task automatic spiFrame(input logic [7:0] expTx);
        lastRx = 8'($random(seed));
        spiQ.push_back(expTx);
        i_ssst_spi_master.frame(lastRx);
    endtask : spiFrame

    task automatic endTest(input string name);
        $display("test %s done", name);
    endtask : endTest

    task automatic finish_test();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test

    always @(posedge clock) begin
        if (apbReq.psel && apbReq.penable && !apbReq.pwrite && apbRsp.pready === 1'h1) begin
            cur = apbQ.pop_front();
            cmpWord("prdata", cur.data & cur.msk, apbRsp.prdata & cur.msk);
            cmpBit("pslverr", cur.err, apbRsp.pslverr);
            cmpBit("irq", cur.irq, irq);
            cmpBit("ioPinFourOe", cur.oe, ioPinFourOe);
        end
    end

    initial begin
        forever begin
            @(i_ssst_spi_master.doneEv);
            cmpWord("master rx", {24'h0, spiQ.pop_front()}, {24'h0, i_ssst_spi_master.rxByte});
        end
    end

    initial begin
        #200000;
        failures++;
        $display("watchdog expired");
        finish_test();
    end

    initial begin
        apbReq = '0;
        rst_n = 1'h0;
        oeExp = 1'h0;
        failures = 0;
        comparisons = 0;
        seed = 35;
        repeat (3) @(posedge clock);
        rst_n <= 1'h1;
        rd(ssst_pkg::ADDR_CTRL, 32'h00000800, 32'hffffffff, 1'h0, 1'h0);
        rd(ssst_pkg::ADDR_MASK, 32'h0, 32'hffffffff, 1'h0, 1'h0);
        rd(ssst_pkg::ADDR_STATUS, 32'h0, 32'hffffffff, 1'h0, 1'h0);
        rd(ssst_pkg::ADDR_BUFSTAT, 32'h0, 32'hffffffff, 1'h0, 1'h0);
        rd(ssst_pkg::ADDR_TXDATA, 32'h0, 32'hffffffff, 1'h0, 1'h0);
        rd(8'h18, 32'h0, 32'h0, 1'h1, 1'h0);
        wr(ssst_pkg::ADDR_CTRL, 32'h00000400);
        rd(ssst_pkg::ADDR_CTRL, 32'h00000400, 32'hffffffff, 1'h0, 1'h0);
        endTest("reset");
        tx0 = 8'($random(seed));
        tx1 = 8'($random(seed));
        wr(ssst_pkg::ADDR_TXDATA, {24'h0, tx0});
        wr(ssst_pkg::ADDR_CTRL, 32'h00000801);
        oeExp = 1'h1;
        spiFrame(tx0);
        rd(ssst_pkg::ADDR_STATUS, 32'h17, 32'hffffffff, 1'h0, 1'h0);
        rd(ssst_pkg::ADDR_BUFSTAT, 32'h000f0006, 32'hffff0007, 1'h0, 1'h0);
        rd(ssst_pkg::ADDR_RXDATA, {lastRx, 24'h0}, 32'hff000000, 1'h0, 1'h0);
        rd(ssst_pkg::ADDR_STATUS, 32'h0, 32'hffffffff, 1'h0, 1'h0);
        endTest("first frame");
        wr(ssst_pkg::ADDR_MASK, 32'h2);
        wr(ssst_pkg::ADDR_TXDATA, {24'h0, tx1});
        // stale word goes out again, the new one waits for the reload
        spiFrame(tx0);
        rd(ssst_pkg::ADDR_STATUS, 32'h13, 32'hffffffff, 1'h0, 1'h1);
        rd(ssst_pkg::ADDR_RXDATA, {lastRx, 24'h0}, 32'hff000000, 1'h0, 1'h0);
        endTest("second frame");
        spiFrame(tx1);
        rd(ssst_pkg::ADDR_STATUS, 32'h16, 32'hffffffff, 1'h0, 1'h1);
        // no receive read between frames: the next store overflows
        spiFrame(tx1);
        rd(ssst_pkg::ADDR_STATUS, 32'h1e, 32'hffffffff, 1'h0, 1'h1);
        endTest("underflow and overflow");
        wr(ssst_pkg::ADDR_CTRL, 32'h00000800);
        oeExp = 1'h0;
        rd(ssst_pkg::ADDR_BUFSTAT, 32'h0, 32'h4, 1'h0, 1'h0);
        endTest("disable");
        // enable with an empty buffer: the stale word goes out and the load underflows
        wr(ssst_pkg::ADDR_CTRL, 32'h00000801);
        oeExp = 1'h1;
        spiFrame(tx1);
        rd(ssst_pkg::ADDR_STATUS, 32'h1e, 32'hffffffff, 1'h0, 1'h1);
        endTest("enable without data");
        finish_test();
    end
endmodule : test_ssst_spi_slave
